// ---- ocram_ctrl.v ----
`include "ocram_regs.vh"
module ocram_ctrl #(
   parameter BYTES = `OCRAM_BYTES
) (
   // Clock and synchronous reset
   input wire core_clk,
   input wire srst,
   // External reset pin, active low, asynchronous to the clock
   input wire external_reset_pin_n,
   // Operating mode pins, static after reset
   input wire [`OCRAM_MODE_W-1:0] mode,
   // Software standby indication
   input wire standby,
   // Processor bus request
   input wire req,
   input wire [`OCRAM_ADDR_W-1:0] addr,
   input wire wr,
   input wire word,
   input wire [15:0] wdata,
   // Processor bus answer
   output wire ready,
   output reg [15:0] rdata,
   output reg [7:0] sysctl_rdata,
   // Off-chip cycle request
   output reg ext_req,
   output reg [`OCRAM_ADDR_W-1:0] ext_addr,
   output reg ext_wr,
   output reg ext_word,
   output reg [15:0] ext_wdata,
   // Current enable state
   output wire internal_memory_enable
);
   localparam AW = 8;
   localparam ST_IDLE = 2'h0;
   localparam ST_RAM = 2'h1;
   localparam ST_DONE = 2'h2;

   reg [7:0] system_control_register;
   reg [1:0] state;
   reg [AW-1:0] word_addr;
   reg wr_hi;
   reg wr_lo;
   reg [15:0] mem_wdata;
   reg byte_rd;
   reg byte_odd;
   reg rst_pin_q;
   wire rst_pin_s;
   wire [15:0] mem_rdata;
   wire in_win;
   wire sysctl_hit;
   wire [AW:0] off;
   wire [`OCRAM_ADDR_W-1:0] win_lo;
   wire [`OCRAM_ADDR_W-1:0] off_full;
   wire [AW-1:0] mem_addr;

   function in_range;
      input [`OCRAM_ADDR_W-1:0] a;
      input [`OCRAM_ADDR_W-1:0] lo;
      input [`OCRAM_ADDR_W-1:0] hi;
      begin
         in_range = (a >= lo) && (a <= hi);
      end
   endfunction

   ocram_sync u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .din(external_reset_pin_n),
      .dout(rst_pin_s)
   );

   ocram_array #(.BYTES(BYTES), .AW(AW)) u_array (
      .core_clk(core_clk),
      .word_addr(mem_addr),
      .wr_hi(wr_hi),
      .wr_lo(wr_lo),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   assign internal_memory_enable =
      system_control_register[`OCRAM_ENABLE_BIT];

   // Window depends on mode; the enable is sampled at request only.
   assign in_win = internal_memory_enable && (
      (((mode == `OCRAM_MODE1) || (mode == `OCRAM_MODE2)) &&
       in_range(addr, `OCRAM_WIN12_LO, `OCRAM_WIN12_HI)) ||
      (((mode == `OCRAM_MODE3) || (mode == `OCRAM_MODE4)) &&
       in_range(addr, `OCRAM_WIN34_LO, `OCRAM_WIN34_HI)));
   assign sysctl_hit = (addr[15:0] == `OCRAM_SYSCTL_ADDR);
   assign win_lo = ((mode == `OCRAM_MODE3) || (mode == `OCRAM_MODE4)) ?
      `OCRAM_WIN34_LO : `OCRAM_WIN12_LO;
   assign off_full = addr - win_lo;
   assign off = off_full[AW:0];
   // The array registers its read, so it is addressed from the request
   // while idle; otherwise read data would lag by one access.
   assign mem_addr = (state == ST_IDLE) ? off[AW:1] : word_addr;
   assign ready = (state == ST_DONE);

   // Enable restored on the rising edge of the external reset pin.
   always @(posedge core_clk) begin
      if (srst) begin
         rst_pin_q <= 1'b1;
      end else begin
         rst_pin_q <= rst_pin_s;
      end
   end

   // Standby is not an input to this register, so it holds.
   always @(posedge core_clk) begin
      if (srst || (rst_pin_s && !rst_pin_q)) begin
         system_control_register <= `OCRAM_SYSCTL_RESET;
      end else if (req && (state == ST_IDLE) && wr && sysctl_hit &&
                   !in_win) begin
         system_control_register <= word ? wdata[15:8] : wdata[15:8];
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         state <= ST_IDLE;
         word_addr <= {AW{1'b0}};
         wr_hi <= 1'b0;
         wr_lo <= 1'b0;
         mem_wdata <= 16'h0000;
         byte_rd <= 1'b0;
         byte_odd <= 1'b0;
         rdata <= 16'h0000;
         sysctl_rdata <= 8'h00;
         ext_req <= 1'b0;
         ext_addr <= {`OCRAM_ADDR_W{1'b0}};
         ext_wr <= 1'b0;
         ext_word <= 1'b0;
         ext_wdata <= 16'h0000;
      end else begin
         wr_hi <= 1'b0;
         wr_lo <= 1'b0;
         ext_req <= 1'b0;
         case (state)
         ST_IDLE: begin
            if (req && in_win) begin
               state <= ST_RAM;
               word_addr <= off[AW:1];
               byte_rd <= !word;
               byte_odd <= off[0];
               if (word) begin
                  // Low address bit ignored: words are even.
                  wr_hi <= wr;
                  wr_lo <= wr;
                  mem_wdata <= wdata;
               end else begin
                  // Byte data sits on the upper lane.
                  wr_hi <= wr && !off[0];
                  wr_lo <= wr && off[0];
                  mem_wdata <= {wdata[15:8], wdata[15:8]};
               end
            end else if (req && sysctl_hit) begin
               state <= ST_DONE;
               sysctl_rdata <= system_control_register;
               rdata <= {system_control_register, 8'h00};
            end else if (req) begin
               ext_req <= 1'b1;
               ext_addr <= addr;
               ext_wr <= wr;
               ext_word <= word;
               ext_wdata <= wdata;
            end
         end
         ST_RAM: begin
            state <= ST_DONE;
            if (byte_rd) begin
               rdata <= {byte_odd ? mem_rdata[7:0] : mem_rdata[15:8],
                         8'h00};
            end else begin
               rdata <= mem_rdata;
            end
         end
         ST_DONE: begin
            state <= ST_IDLE;
         end
         default: begin
            state <= ST_IDLE;
         end
         endcase
      end
   end
endmodule

// ---- ocram_regs.vh ----
`ifndef OCRAM_REGS_VH
`define OCRAM_REGS_VH
`define OCRAM_SYSCTL_ADDR 16'hfff2
`define OCRAM_SYSCTL_RESET 8'h0b
`define OCRAM_ENABLE_BIT 0
`define OCRAM_BYTES 512
`define OCRAM_ADDR_W 24
`define OCRAM_WIN12_LO 24'h0ffd10
`define OCRAM_WIN12_HI 24'h0fff0f
`define OCRAM_WIN34_LO 24'hfffd10
`define OCRAM_WIN34_HI 24'hffff0f
`define OCRAM_MODE_W 3
`define OCRAM_MODE1 3'h1
`define OCRAM_MODE2 3'h2
`define OCRAM_MODE3 3'h3
`define OCRAM_MODE4 3'h4
`define OCRAM_ACCESS_STATES 2'h2
`endif

// ---- ocram_sync.v ----
module ocram_sync (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Asynchronous level in, synchronised level out
   input wire din,
   output reg dout
);
   reg meta;
   always @(posedge core_clk) begin
      if (srst) begin
         meta <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

// ---- ocram_array.v ----
module ocram_array #(
   parameter BYTES = 512,
   parameter AW = 8
) (
   // Clock
   input wire core_clk,
   // Word-addressed port with per-byte write enables
   input wire [AW-1:0] word_addr,
   input wire wr_hi,
   input wire wr_lo,
   input wire [15:0] wdata,
   output reg [15:0] rdata
);
   reg [7:0] mem_hi [0:BYTES/2-1];
   reg [7:0] mem_lo [0:BYTES/2-1];
   // The array has no reset so it can map onto a real SRAM macro.
   always @(posedge core_clk) begin
      if (wr_hi) begin
         mem_hi[word_addr] <= wdata[15:8];
      end
      if (wr_lo) begin
         mem_lo[word_addr] <= wdata[7:0];
      end
      rdata <= {mem_hi[word_addr], mem_lo[word_addr]};
   end
endmodule

// ---- ocram_chk_sva.sv ----
module ocram_chk (
   // Clock and resets
   input wire core_clk,
   input wire srst,
   input wire external_reset_pin_n,
   // Mode and power state
   input wire [2:0] mode,
   input wire standby,
   // Core bus
   input wire req,
   input wire [23:0] addr,
   input wire wr,
   input wire word,
   input wire ready,
   input wire [15:0] rdata,
   input wire ext_req,
   input wire [23:0] ext_addr,
   input wire internal_memory_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   wire lo = mode == 3'h1 || mode == 3'h2;
   wire hi = mode == 3'h3 || mode == 3'h4;
   wire win = lo && addr >= 24'h0ffd10 && addr <= 24'h0fff0f ||
      hi && addr >= 24'hfffd10 && addr <= 24'hffff0f;
   wire hit = win && internal_memory_enable;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence ram_answer;
      !ready ##1 ready;
   endsequence
   chk_ram_two_states: assert property ($rose(req) && hit |=> ram_answer)
      else $error("ram answer late");
   chk_ram_no_ext: assert property ($rose(req) && hit |=> !ext_req [*2])
      else $error("ram access went out");
   chk_off_chip_go: assert property ($rose(req) && win && !hit |=>
      ext_req && ext_addr == $past(addr)) else $error("no off-chip cycle");
   chk_byte_lane: assert property ($rose(req) && hit && !wr && !word |->
      ##2 rdata[7:0] == 8'h00) else $error("byte low lane busy");
   chk_reg_answer: assert property ($rose(req) && !win &&
      addr[15:0] == 16'hfff2 |=> ready && !ext_req) else $error("ctrl answer");
   chk_reset_enable: assert property (disable iff (1'b0) srst |=>
      internal_memory_enable) else $error("enable not set by reset");
   chk_pin_reload: assert property ($rose(external_reset_pin_n) |->
      ##[2:4] internal_memory_enable) else $error("pin reset ignored");
   chk_standby_keep: assert property (standby && !req &&
      external_reset_pin_n |=> $stable(internal_memory_enable))
      else $error("standby moved enable");
endmodule
bind ocram_ctrl ocram_chk u_chk (.core_clk, .srst, .external_reset_pin_n,
   .mode, .standby, .req, .addr, .wr, .word, .ready, .rdata, .ext_req,
   .ext_addr, .internal_memory_enable);

// ---- ocram_core.sv ----
module ocram_core (
   // Clock and answers
   input wire core_clk,
   input wire ready,
   input wire ext_req,
   input wire [15:0] rdata,
   // Request
   output logic req = 1'b0,
   output logic [23:0] addr = 24'h0,
   output logic wr = 1'b0,
   output logic word = 1'b0,
   output logic [15:0] wdata = 16'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Word requests always start even; released addr and wdata lines are inverted, while wr and word keep their old values.
   task automatic acc(input logic w, wd, input logic [23:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic x);
      int n;
      @(posedge core_clk);
      #1;
      req = 1'b1;
      addr = wd ? {a[23:1], 1'b0} : a;
      wr = w;
      word = wd;
      wdata = d;
      @(posedge core_clk);
      #1;
      x = ext_req;
      n = 0;
      if (!x) begin
         while (!ready && n < 8) begin
            @(negedge core_clk);
            n++;
         end
         @(posedge core_clk);
         #1;
      end
      q = rdata;
      req = 1'b0;
      addr = ~addr;
      wdata = ~wdata;
   endtask
endmodule

// ---- ocram_ctrl_bench.sv ----
module ocram_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, srst = 1, pin_n = 1, standby = 0, x;
   logic [2:0] mode = 3'h1;
   logic req, wr, word, ready, ext_req, en, ext_wr, ext_word;
   logic [23:0] addr, ext_addr, base, top;
   logic [15:0] wdata, rdata, q, ext_wdata;
   logic [7:0] sysctl_rdata;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   initial forever #10 core_clk = ~core_clk;
   ocram_ctrl u_dut (.core_clk, .srst, .external_reset_pin_n(pin_n), .mode,
      .standby, .req, .addr, .wr, .word, .wdata, .ready, .rdata,
      .sysctl_rdata, .ext_req, .ext_addr, .ext_wr, .ext_word,
      .ext_wdata, .internal_memory_enable(en));
   ocram_core u_core (.core_clk, .ready, .ext_req, .rdata, .req, .addr,
      .wr, .word, .wdata);
   task chk(input string n, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_sim;
      if (error_cnt == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      for (int m = 1; m < 5; m++) begin
         @(posedge core_clk);
         #1;
         mode = m[2:0];
         srst = 1;
         repeat (12) @(posedge core_clk);
         #1;
         srst = 0;
         base = m < 3 ? 24'h0ffd10 : 24'hfffd10;
         top = m < 3 ? 24'h0fff0f : 24'hffff0f;
         chk("enable", 1, en);
         u_core.acc(1, 1, base, 16'h1234, q, x);
         u_core.acc(1, 1, top - 1, 16'h5566, q, x);
         u_core.acc(1, 0, top, 16'hab00, q, x);
         u_core.acc(0, 1, base, 0, q, x);
         chk("word", 16'h1234, q);
         u_core.acc(0, 1, top - 1, 0, q, x);
         chk("lanes", 16'h55ab, q);
         u_core.acc(0, 0, top, 0, q, x);
         chk("byte", 16'hab00, q);
         u_core.acc(0, 0, top + 1, 0, q, x);
         chk("past end", 1, x);
         u_core.acc(1, 0, 24'hfffff2, 16'h0a00, q, x);
         u_core.acc(0, 0, 24'hfffff2, 0, q, x);
         chk("ctrl", 16'h0a, sysctl_rdata);
         chk("ctrl lane", 16'h0a00, q);
         u_core.acc(1, 1, base, 16'hbeef, q, x);
         chk("ext write", 1, x);
         chk("ext wdata", 16'hbeef, ext_wdata);
         chk("ext kind wr", 16'h3, {ext_wr, ext_word});
         u_core.acc(0, 1, base, 0, q, x);
         chk("off-chip", 1, x);
         chk("ext addr", base[15:0], ext_addr[15:0]);
         chk("ext kind rd", 16'h1, {ext_wr, ext_word});
         standby = 1;
         repeat (4) @(posedge core_clk);
         #1;
         chk("standby", 0, en);
         standby = 0;
         pin_n = 0;
         repeat (4) @(posedge core_clk);
         #1;
         pin_n = 1;
         repeat (6) @(posedge core_clk);
         #1;
         chk("pin reset", 1, en);
         u_core.acc(0, 1, base, 0, q, x);
         chk("back on", 16'h1234, x ? 16'h0 : q);
      end
      end_sim();
   end
endmodule
